//--- include/asyncs_map.svh
// Purpose: Register offsets, field positions, reset values and counts.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Included by the serial core and its testbench.
`ifndef ASYNCS_MAP_SVH
`define ASYNCS_MAP_SVH

// Register byte offsets.
`define ASY_OFF_CTRL 12'h000
`define ASY_OFF_STAT 12'h004
`define ASY_OFF_DATA 12'h008
`define ASY_OFF_BAUD 12'h00C

// Control register fields.
`define ASY_C_TX_ON 0
`define ASY_C_RX_ON 1
`define ASY_C_BREAK_SEND 2
`define ASY_C_NINE_BIT 3
`define ASY_C_TWO_STOP_SEL 4
`define ASY_C_LONG_BREAK_SEL 5
`define ASY_C_TX_INVERT 6
`define ASY_C_RX_INVERT 7
`define ASY_CTRL_W 8

// Status register fields.
`define ASY_S_TX_BUFFER_EMPTY 0
`define ASY_S_TX_COMPLETE 1
`define ASY_S_RX_BUFFER_FULL 2
`define ASY_S_OVERRUN 3
`define ASY_S_FRAMING_ERROR 4

// Reset values.
`define ASY_CTRL_RST 8'h00
`define ASY_BAUD_RST 16'h0004

// Timing counts.
`define ASY_OVERSAMPLE 5'h10
`define ASY_BASE_LEN 4'hA
`define ASY_LONG_EXTRA 4'h3

`endif

//--- include/asyncs_pkg.sv
// Purpose: Types shared by the serial core.
// Assumes: Nothing beyond the map header.
// Notes: Constants live in the map header.
package asyncs_pkg;

   typedef enum logic [1:0] {
      ASYNCS_LD_DATA,
      ASYNCS_LD_IDLE,
      ASYNCS_LD_BREAK
   } asyncs_load_t;

   typedef enum logic [1:0] {
      ASYNCS_RX_IDLE,
      ASYNCS_RX_START,
      ASYNCS_RX_DATA,
      ASYNCS_RX_STOP
   } asyncs_rx_state_t;

endpackage

//--- rtl/asyncs_baud.sv
// Purpose: Divides the bus clock into the 16x baud tick.
// Assumes: A divisor of zero behaves as one.
// Notes: Shared by transmitter and receiver.
module asyncs_baud #(
   parameter int DIV_W = 16
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Divisor and tick.
   input wire logic [DIV_W-1:0] divisor,
   output logic tick
);

   logic [DIV_W-1:0] cnt_ff;
   logic [DIV_W-1:0] limit;

   assign limit = (divisor == '0) ? '0 : divisor - 1'b1;
   assign tick = (cnt_ff >= limit);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= '0;
      end else if (tick) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

endmodule

//--- rtl/asyncs_core.sv
// Purpose: Asynchronous serial transmitter and receiver with APB registers.
// Assumes: Serial input is asynchronous and passes two flip-flops.
// Notes: Baud tick comes from the bus clock through one divider.
// Function
// RULE1: Baud generator for both directions runs from the bus clock.
// RULE2: Receiver resynchronises bit timing on every falling input edge in a frame; the code ignores edges in the stop state.
// RULE3: Invert is clear after reset, line idles high, invert flips the output.
// RULE4: Enabling the transmitter queues one idle-level preamble frame first.
// RULE5: Transmit frame is 10, 11 or 12 bits from nine-bit and stop selects.
// RULE6: Eight-bit one-stop frame is start, eight data, one stop.
// RULE7: Free shifter loads waiting data on a baud tick and sets buffer empty.
// RULE8: Software reads status before each data write or the write is dropped.
// RULE9: Nothing waiting after a stop bit sets complete and idles the line.
// RULE10: Disabling keeps the pin until data, idle and break frames are done; the code leaves buffered data unsent until re-enable and releases the pin.
// RULE11: Break is all zeros, 10 bits plus options, or 13 to 15 long.
// RULE12: Writing break send one then zero queues one break frame.
// RULE13: Break send still one when a break loads queues another break.
// RULE14: Writing enable zero then one queues one idle frame of ones.
// RULE15: Pin stays driven over a quick disable and re-enable toggle.
// RULE16: Receive invert flips the input; receive enable turns the receiver on.
// RULE17: Frame is zero start, 8 or 9 data LSB first, 1 or 2 ones.
// RULE18: Completed character moves to an empty buffer and sets buffer full.
// RULE19: Completion while full sets overrun and keeps the old character.
// RULE20: Buffer full clears by an access sequence, never by a write.
// RULE21: The sequence is a status read with full set, then a data read.
module asyncs_core #(
   parameter int DIV_W = 16
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic sys_rst,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial pins.
   input wire logic rxd_in,
   output logic txd_out,
   output logic txd_oe
);
`include "asyncs_map.svh"

   ////////////////////////////////////////////////////////////////////////
   // Register bus.
   logic [`ASY_CTRL_W-1:0] ctrl_ff;
   logic [DIV_W-1:0] baud_ff;
   logic [31:0] prdata_ff;
   logic setup_ph, access, wr, rd, mapped;
   logic ctrl_wr, data_wr, stat_rd, data_rd;
   logic tx_buffer_empty_ff, tc_ff, rx_buffer_full_ff, ovr_ff, fe_ff;
   logic [8:0] rx_buf_ff;
   logic stat_seen_ff, rx_armed_ff;

   assign setup_ph = psel && !penable;
   assign access = psel && penable;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;
   assign mapped = (paddr == `ASY_OFF_CTRL) || (paddr == `ASY_OFF_STAT)
                   || (paddr == `ASY_OFF_DATA) || (paddr == `ASY_OFF_BAUD);
   assign ctrl_wr = wr && (paddr == `ASY_OFF_CTRL);
   assign data_wr = wr && (paddr == `ASY_OFF_DATA);
   assign stat_rd = rd && (paddr == `ASY_OFF_STAT);
   assign data_rd = rd && (paddr == `ASY_OFF_DATA);
   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata = prdata_ff;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         prdata_ff <= 32'h00000000;
      end else if (setup_ph && !pwrite) begin
         case (paddr)
            `ASY_OFF_CTRL: prdata_ff <= {24'h000000, ctrl_ff};
            `ASY_OFF_STAT: prdata_ff <= {27'h0000000, fe_ff, ovr_ff,
                                         rx_buffer_full_ff, tc_ff, tx_buffer_empty_ff};
            `ASY_OFF_DATA: prdata_ff <= {23'h000000, rx_buf_ff};
            `ASY_OFF_BAUD: prdata_ff <= {{(32-DIV_W){1'b0}}, baud_ff};
            default: prdata_ff <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_ff <= `ASY_CTRL_RST; // RULE3
         baud_ff <= DIV_W'(`ASY_BAUD_RST);
      end else begin
         if (ctrl_wr) begin
            ctrl_ff <= pwdata[`ASY_CTRL_W-1:0];
         end
         if (wr && (paddr == `ASY_OFF_BAUD)) begin
            baud_ff <= pwdata[DIV_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Baud tick, shared by both directions.
   logic tick;

   asyncs_baud #(.DIV_W(DIV_W)) u_baud ( // RULE1
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .divisor(baud_ff),
      .tick(tick)
   );

   logic nine, two_stop, tx_on;
   logic [3:0] frame_len, break_len;

   assign nine = ctrl_ff[`ASY_C_NINE_BIT];
   assign two_stop = ctrl_ff[`ASY_C_TWO_STOP_SEL];
   assign tx_on = ctrl_ff[`ASY_C_TX_ON];
   assign frame_len = `ASY_BASE_LEN + {3'h0, nine} + {3'h0, two_stop}; // RULE5
   assign break_len = frame_len
                      + (ctrl_ff[`ASY_C_LONG_BREAK_SEL] ? `ASY_LONG_EXTRA
                                                        : 4'h0); // RULE11

   ////////////////////////////////////////////////////////////////////////
   // Transmit queue and flags.
   logic [8:0] tx_buf_ff;
   logic idle_q_ff, brk_q_ff;
   logic tx_busy_ff, tx_is_brk_ff;
   logic [11:0] tx_sh_ff;
   logic [3:0] tx_bits_ff, tx_ph_ff;
   logic tx_free, tx_load, tx_bit_end, tx_done, data_wait;
   logic tx_on_rise, brk_fall;
   asyncs_pkg::asyncs_load_t ld_kind;

   assign tx_on_rise = ctrl_wr && !tx_on && pwdata[`ASY_C_TX_ON];
   assign brk_fall = ctrl_wr && ctrl_ff[`ASY_C_BREAK_SEND]
                     && !pwdata[`ASY_C_BREAK_SEND];
   assign data_wait = !tx_buffer_empty_ff && tx_on;
   assign tx_free = !tx_busy_ff && tick;
   assign tx_load = tx_free && (idle_q_ff || brk_q_ff || data_wait); // RULE7
   assign tx_bit_end = tx_busy_ff && tick && (tx_ph_ff == 4'hF);
   assign tx_done = tx_bit_end && (tx_bits_ff == 4'h1);

   // Preamble and idle frames go first, then breaks, then data.
   always_comb begin
      if (idle_q_ff) begin
         ld_kind = asyncs_pkg::ASYNCS_LD_IDLE;
      end else if (brk_q_ff) begin
         ld_kind = asyncs_pkg::ASYNCS_LD_BREAK;
      end else begin
         ld_kind = asyncs_pkg::ASYNCS_LD_DATA;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         idle_q_ff <= 1'b0;
         brk_q_ff <= 1'b0;
      end else begin
         if (tx_on_rise) begin
            idle_q_ff <= 1'b1; // RULE4 RULE14
         end else if (tx_load && ld_kind == asyncs_pkg::ASYNCS_LD_IDLE) begin
            idle_q_ff <= 1'b0;
         end
         if (brk_fall) begin
            brk_q_ff <= 1'b1; // RULE12
         end else if (tx_load && ld_kind == asyncs_pkg::ASYNCS_LD_BREAK) begin
            brk_q_ff <= ctrl_ff[`ASY_C_BREAK_SEND]; // RULE13
         end
      end
   end

   // A data write counts only after a status read saw the buffer empty.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         stat_seen_ff <= 1'b0;
         tx_buffer_empty_ff <= 1'b1;
         tx_buf_ff <= 9'h000;
      end else begin
         if (stat_rd && tx_buffer_empty_ff) begin
            stat_seen_ff <= 1'b1;
         end else if (data_wr) begin
            stat_seen_ff <= 1'b0;
         end
         if (tx_load && ld_kind == asyncs_pkg::ASYNCS_LD_DATA) begin
            tx_buffer_empty_ff <= 1'b1; // RULE7
         end else if (data_wr && stat_seen_ff && tx_buffer_empty_ff) begin
            tx_buffer_empty_ff <= 1'b0; // RULE8
            tx_buf_ff <= pwdata[8:0];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         tc_ff <= 1'b1;
      end else if (tx_done && !idle_q_ff && !brk_q_ff && !data_wait) begin
         tc_ff <= 1'b1; // RULE9
      end else if (tx_load || tx_on_rise || brk_fall || data_wr) begin
         tc_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit shifter.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         tx_busy_ff <= 1'b0;
         tx_is_brk_ff <= 1'b0;
         tx_sh_ff <= 12'hFFF;
         tx_bits_ff <= 4'h0;
         tx_ph_ff <= 4'h0;
      end else if (tx_load) begin
         tx_busy_ff <= 1'b1;
         tx_ph_ff <= 4'h0;
         tx_is_brk_ff <= (ld_kind == asyncs_pkg::ASYNCS_LD_BREAK);
         case (ld_kind)
            asyncs_pkg::ASYNCS_LD_IDLE: begin
               tx_sh_ff <= 12'hFFF;
               tx_bits_ff <= frame_len;
            end
            asyncs_pkg::ASYNCS_LD_BREAK: begin
               tx_sh_ff <= 12'h000; // RULE11
               tx_bits_ff <= break_len;
            end
            default: begin
               tx_sh_ff <= {2'h3, nine ? tx_buf_ff[8] : 1'b1,
                            tx_buf_ff[7:0], 1'b0}; // RULE6 RULE17
               tx_bits_ff <= frame_len;
            end
         endcase
      end else if (tx_busy_ff && tick) begin
         tx_ph_ff <= tx_ph_ff + 4'h1;
         if (tx_ph_ff == 4'hF) begin
            tx_bits_ff <= tx_bits_ff - 4'h1;
            // Breaks keep shifting zeros in; frames shift ones in.
            tx_sh_ff <= {!tx_is_brk_ff, tx_sh_ff[11:1]};
            if (tx_bits_ff == 4'h1) begin
               tx_busy_ff <= 1'b0;
            end
         end
      end
   end

   // Pin stays driven while enabled, shifting or holding queued idle or break frames.
   assign txd_oe = tx_on || tx_busy_ff || idle_q_ff || brk_q_ff
                   || data_wait; // RULE10 RULE15
   assign txd_out = (tx_busy_ff ? tx_sh_ff[0] : 1'b1)
                    ^ ctrl_ff[`ASY_C_TX_INVERT]; // RULE3

   ////////////////////////////////////////////////////////////////////////
   // Receive input synchroniser and edge detect.
   logic rx_s1_ff, rx_s2_ff, rx_prev_ff, rx_line, rx_fall;
   asyncs_pkg::asyncs_rx_state_t rx_st_ff;
   logic [3:0] rx_ph_ff, rx_cnt_ff;
   logic [8:0] rx_sh_ff;
   logic rx_done, rx_bad, rx_on;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rx_s1_ff <= 1'b1;
         rx_s2_ff <= 1'b1;
         rx_prev_ff <= 1'b1;
      end else begin
         rx_s1_ff <= rxd_in;
         rx_s2_ff <= rx_s1_ff;
         rx_prev_ff <= rx_line;
      end
   end

   assign rx_on = ctrl_ff[`ASY_C_RX_ON]; // RULE16
   assign rx_line = rx_s2_ff ^ ctrl_ff[`ASY_C_RX_INVERT]; // RULE16
   assign rx_fall = rx_prev_ff && !rx_line;

   ////////////////////////////////////////////////////////////////////////
   // Receive sequencer: samples mid-bit, ends start and data bits at phase 15, finishes at the last stop bit's mid-bit sample.
   logic rx_mid, rx_end;

   assign rx_mid = tick && (rx_ph_ff == 4'h7);
   assign rx_end = tick && (rx_ph_ff == 4'hF);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rx_st_ff <= asyncs_pkg::ASYNCS_RX_IDLE;
         rx_ph_ff <= 4'h0;
         rx_cnt_ff <= 4'h0;
         rx_sh_ff <= 9'h000;
         rx_bad <= 1'b0;
         rx_done <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (!rx_on) begin
            rx_st_ff <= asyncs_pkg::ASYNCS_RX_IDLE;
         end else if (rx_fall && rx_st_ff != asyncs_pkg::ASYNCS_RX_STOP) begin
            rx_ph_ff <= 4'h0; // RULE2
            if (rx_st_ff == asyncs_pkg::ASYNCS_RX_IDLE) begin
               rx_st_ff <= asyncs_pkg::ASYNCS_RX_START;
            end
         end else if (tick) begin
            rx_ph_ff <= rx_ph_ff + 4'h1;
            case (rx_st_ff)
               asyncs_pkg::ASYNCS_RX_START: begin
                  if (rx_mid && rx_line) begin
                     rx_st_ff <= asyncs_pkg::ASYNCS_RX_IDLE;
                  end else if (rx_end) begin
                     rx_st_ff <= asyncs_pkg::ASYNCS_RX_DATA;
                     rx_cnt_ff <= nine ? 4'h9 : 4'h8;
                     rx_bad <= 1'b0;
                  end
               end
               asyncs_pkg::ASYNCS_RX_DATA: begin
                  if (rx_mid) begin
                     rx_sh_ff <= {rx_line, rx_sh_ff[8:1]}; // RULE17
                     rx_cnt_ff <= rx_cnt_ff - 4'h1;
                  end else if (rx_end && rx_cnt_ff == 4'h0) begin
                     rx_st_ff <= asyncs_pkg::ASYNCS_RX_STOP;
                     rx_cnt_ff <= two_stop ? 4'h2 : 4'h1;
                  end
               end
               asyncs_pkg::ASYNCS_RX_STOP: begin
                  if (rx_mid) begin
                     rx_bad <= rx_bad || !rx_line;
                     if (rx_cnt_ff == 4'h1) begin
                        rx_done <= 1'b1;
                        rx_st_ff <= asyncs_pkg::ASYNCS_RX_IDLE;
                     end
                     rx_cnt_ff <= rx_cnt_ff - 4'h1;
                  end
               end
               default: rx_st_ff <= asyncs_pkg::ASYNCS_RX_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive buffer and flags; a new event wins over a clear.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rx_buf_ff <= 9'h000;
         rx_buffer_full_ff <= 1'b0;
         ovr_ff <= 1'b0;
         fe_ff <= 1'b0;
         rx_armed_ff <= 1'b0;
      end else begin
         if (stat_rd && (rx_buffer_full_ff || ovr_ff || fe_ff)) begin
            rx_armed_ff <= 1'b1; // RULE21
         end else if (data_rd) begin
            rx_armed_ff <= 1'b0;
         end
         if (rx_done && rx_buffer_full_ff) begin
            ovr_ff <= 1'b1; // RULE19
         end else if (data_rd && rx_armed_ff) begin
            ovr_ff <= 1'b0;
         end
         if (rx_done && !rx_buffer_full_ff) begin
            rx_buffer_full_ff <= 1'b1; // RULE18
            rx_buf_ff <= nine ? rx_sh_ff : {1'b0, rx_sh_ff[8:1]};
            fe_ff <= rx_bad;
         end else if (data_rd && rx_armed_ff) begin
            rx_buffer_full_ff <= 1'b0; // RULE20 RULE21
            fe_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   chk_tx_idle_level: assert property ( // RULE3
      !tx_busy_ff |-> txd_out != ctrl_ff[`ASY_C_TX_INVERT])
      else $error("Idle transmit line is not at idle level.");
   chk_break_zeros: assert property ( // RULE11
      tx_busy_ff && tx_is_brk_ff |-> txd_out == ctrl_ff[`ASY_C_TX_INVERT])
      else $error("Break frame sent a one.");
   chk_load_sets_empty: assert property ( // RULE7
      tx_load && ld_kind == asyncs_pkg::ASYNCS_LD_DATA
      |=> tx_buffer_empty_ff && tx_busy_ff && tx_bits_ff == frame_len)
      else $error("Data load did not free the buffer.");
   chk_pin_held: assert property ( // RULE10
      tx_busy_ff || brk_q_ff || idle_q_ff |-> txd_oe)
      else $error("Pin released with work pending.");
   chk_preamble_queue: assert property ( // RULE4
      tx_on_rise |=> idle_q_ff ##1 !tc_ff)
      else $error("Enable did not queue a preamble.");
   chk_break_requeue: assert property ( // RULE13
      tx_load && ld_kind == asyncs_pkg::ASYNCS_LD_BREAK
      && ctrl_ff[`ASY_C_BREAK_SEND] && !brk_fall |=> brk_q_ff)
      else $error("Held break send did not queue another break.");
   chk_rx_fill: assert property ( // RULE18
      rx_done && !rx_buffer_full_ff |=> rx_buffer_full_ff && !ovr_ff || $past(ovr_ff))
      else $error("Completed character did not fill the buffer.");
   chk_rx_overrun: assert property ( // RULE19
      rx_done && rx_buffer_full_ff |=> ovr_ff && $stable(rx_buf_ff))
      else $error("Overrun not flagged or buffer overwritten.");
   chk_rx_clear: assert property ( // RULE21
      data_rd && rx_armed_ff && !rx_done |=> !rx_buffer_full_ff)
      else $error("Status then data read did not clear buffer full.");
   chk_rx_resync: assert property ( // RULE2
      rx_on && rx_fall && rx_st_ff != asyncs_pkg::ASYNCS_RX_STOP
      |=> rx_ph_ff == 4'h0)
      else $error("Falling edge did not resynchronise bit timing.");

endmodule

//--- tb/asyncs_remote.sv
// Purpose: Remote serial device facing the core's serial pins.
// Assumes: Bit time of BIT bus clocks, eight data bits, one stop bit.
// Notes: Decodes what the core sends and sends characters on request.
module asyncs_remote #(
   parameter int BIT = 16
) (
   // Clock.
   input wire logic clk_sys,
   // Serial lines.
   input wire logic line_in,
   output logic line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got;
   int frames;
   int run;
   int low_len;
   time t_fall;

   initial begin
      line_out = 1'b1;
      frames = 0;
      run = 0;
      low_len = 0;
      t_fall = 0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Length of the last low stretch on the line, in clocks.
   always @(posedge clk_sys) begin
      if (line_in === 1'b0) begin
         run <= run + 1;
      end else begin
         if (run != 0) begin
            low_len <= run;
         end
         run <= 0;
      end
   end

   // Start, eight data bits LSB first, then one stop bit.
   always begin
      @(negedge line_in);
      t_fall = $time;
      repeat (BIT / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge clk_sys);
         got[i] = line_in;
      end
      repeat (BIT) @(posedge clk_sys);
      frames++;
   end

   ////////////////////////////////////////////////////////////////////////
   // The task drives the line high for the stop bit and leaves it there, so it idles high between characters.
   task automatic send(input logic [7:0] b);
      line_out <= 1'b0;
      repeat (BIT) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         line_out <= b[i];
         repeat (BIT) @(posedge clk_sys);
      end
      line_out <= 1'b1;
      repeat (BIT) @(posedge clk_sys);
   endtask
endmodule

//--- tb/asyncs_core_tb.sv
// Purpose: Self-checking bench for the serial core over APB.
// Assumes: Divisor set to one, so a bit lasts 16 clocks.
// Notes: The remote model decodes the output and drives the input.
`include "asyncs_map.svh"
module asyncs_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, slv;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic rxd_in, txd_out, txd_oe;
   int err_total, total_checks, f0;
   time t0;

   asyncs_core asyncs_core_i (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd_in(rxd_in), .txd_out(txd_out),
      .txd_oe(txd_oe));
   asyncs_remote asyncs_remote_i (.clk_sys(clk_sys),
      .line_in(txd_out), .line_out(rxd_in));

   initial clk_sys = 1'b0;
   always #25 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e,
         input string m);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      q = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic wait_tc;
      int n;
      n = 0;
      q = 32'h0;
      while (q[`ASY_S_TX_COMPLETE] !== 1'b1 && n < 400) begin
         apb(1'b0, `ASY_OFF_STAT, 32'h0);
         n++;
      end
      if (n >= 400) begin
         err_total++;
         $display("[FAIL] %0t tx complete timeout", $time);
      end
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk_sys);
      err_total++;
      final_report;
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      err_total = 0;
      total_checks = 0;
      sys_rst = 1'b1;
      {psel, penable, pwrite} = 3'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      chk({30'h0, txd_oe, txd_out}, 32'h1, "idle pins");
      apb(1'b0, `ASY_OFF_CTRL, 32'h0);
      chk(q, 32'h0, "ctrl reset");
      apb(1'b0, `ASY_OFF_STAT, 32'h0);
      chk(q, 32'h3, "status reset");
      apb(1'b0, 12'h010, 32'h0);
      chk({q[30:0], slv}, 32'h1, "unmapped");
      $display("test reset done");
      apb(1'b1, `ASY_OFF_BAUD, 32'h1);
      apb(1'b1, `ASY_OFF_CTRL, 32'h1);
      t0 = $time;
      chk({30'h0, txd_oe, txd_out}, 32'h3, "preamble level");
      apb(1'b0, `ASY_OFF_STAT, 32'h0);
      apb(1'b1, `ASY_OFF_DATA, 32'hA5);
      wait_tc;
      chk(asyncs_remote_i.got, 32'hA5, "tx data");
      chk(asyncs_remote_i.t_fall - t0 >= 7900, 32'h1, "preamble");
      chk(txd_out, 32'h1, "tx idle");
      $display("test tx done");
      apb(1'b0, `ASY_OFF_STAT, 32'h0);
      apb(1'b1, `ASY_OFF_DATA, 32'h11);
      apb(1'b1, `ASY_OFF_DATA, 32'h22);
      wait_tc;
      chk(asyncs_remote_i.frames, 32'h2, "unread write");
      chk(asyncs_remote_i.got, 32'h11, "second data");
      $display("test status gate done");
      apb(1'b0, `ASY_OFF_STAT, 32'h0);
      apb(1'b1, `ASY_OFF_DATA, 32'h5A);
      apb(1'b1, `ASY_OFF_CTRL, 32'h0);
      chk(txd_oe, 32'h1, "held pin");
      wait_tc;
      repeat (20) @(posedge clk_sys);
      chk(asyncs_remote_i.got, 32'h5A, "finish char");
      chk(txd_oe, 32'h0, "pin released");
      $display("test disable done");
      // Bit 0 of lb selects the long break, bit 1 nine bits and two stops.
      for (int lb = 0; lb < 4; lb++) begin
         logic [31:0] m;
         int blen;
         m = ((lb & 1) << 5) | ((lb & 2) * 12);
         blen = 10 + 3 * (lb & 1) + (lb & 2);
         apb(1'b1, `ASY_OFF_CTRL, 32'h1 | m);
         wait_tc;
         apb(1'b1, `ASY_OFF_CTRL, 32'h5 | m);
         apb(1'b1, `ASY_OFF_CTRL, 32'h1 | m);
         wait_tc;
         repeat (4) @(posedge clk_sys);
         chk(asyncs_remote_i.low_len, blen * 16, "break");
      end
      // Break send held high across loads keeps queueing further breaks.
      f0 = asyncs_remote_i.frames;
      apb(1'b1, `ASY_OFF_CTRL, 32'h0);
      apb(1'b1, `ASY_OFF_CTRL, 32'h1);
      apb(1'b1, `ASY_OFF_CTRL, 32'h5);
      apb(1'b1, `ASY_OFF_CTRL, 32'h1);
      apb(1'b1, `ASY_OFF_CTRL, 32'h5);
      repeat (390) @(posedge clk_sys);
      apb(1'b1, `ASY_OFF_CTRL, 32'h1);
      wait_tc;
      repeat (4) @(posedge clk_sys);
      chk(asyncs_remote_i.frames - f0, 32'h3, "held break");
      chk(asyncs_remote_i.low_len, 32'hA0, "held length");
      $display("test break done");
      apb(1'b1, `ASY_OFF_CTRL, 32'h0);
      asyncs_remote_i.send(8'h44);
      repeat (8) @(posedge clk_sys);
      apb(1'b0, `ASY_OFF_STAT, 32'h0);
      chk(q, 32'h3, "rx off");
      apb(1'b1, `ASY_OFF_CTRL, 32'h2);
      asyncs_remote_i.send(8'h3C);
      repeat (8) @(posedge clk_sys);
      apb(1'b0, `ASY_OFF_STAT, 32'h0);
      chk(q, 32'h7, "rx full");
      apb(1'b0, `ASY_OFF_DATA, 32'h0);
      chk(q, 32'h3C, "rx data");
      apb(1'b0, `ASY_OFF_STAT, 32'h0);
      chk(q, 32'h3, "full cleared");
      asyncs_remote_i.send(8'h11);
      asyncs_remote_i.send(8'h22);
      repeat (8) @(posedge clk_sys);
      apb(1'b0, `ASY_OFF_STAT, 32'h0);
      chk(q, 32'hF, "overrun");
      apb(1'b0, `ASY_OFF_DATA, 32'h0);
      chk(q, 32'h11, "kept char");
      $display("test rx done");
      apb(1'b1, `ASY_OFF_CTRL, 32'h40);
      chk(txd_out, 32'h0, "inverted idle");
      $display("test invert done");
      final_report;
   end
endmodule
